// ===== core/asi_defs.svh
// register offsets, field positions, reset values and counts of the serial interface
`ifndef ASI_DEFS_SVH
`define ASI_DEFS_SVH

`define ASI_OFS_PRI      16'hff20
`define ASI_OFS_IEN      16'hff23
`define ASI_OFS_IFAC     16'hff25
`define ASI_OFS_SETUP    16'hff48
`define ASI_OFS_CTRL     16'hff49
`define ASI_OFS_DATA     16'hff4a

`define ASI_PRI_LSB      4
`define ASI_SET_PAR_EN   6
`define ASI_SET_PAR_ODD  5
`define ASI_SET_CS_LSB   3
`define ASI_SET_MD_LSB   1
`define ASI_SET_EN       0
`define ASI_CTL_FER      6
`define ASI_CTL_PER      5
`define ASI_CTL_OER      4
`define ASI_CTL_RXTRG    3
`define ASI_CTL_RXEN     2
`define ASI_CTL_TXTRG    1
`define ASI_CTL_TXEN     0
`define ASI_IRQ_ERR      2
`define ASI_IRQ_RX       1
`define ASI_IRQ_TX       0

`define ASI_RST_SETUP    7'h00
`define ASI_RST_PRI      2'h0
`define ASI_RST_IEN      3'h0

`define ASI_OVS_LAST     4'hf
`define ASI_OVS_MID      4'h7
`define ASI_SYNC_BITS    4'h8
`define ASI_LAST_DIV4    4'h3
`define ASI_LAST_DIV8    4'h7
`define ASI_LAST_DIV16   4'hf

`define ASI_OE_ASYNC     4'h6
`define ASI_OE_MASTER    4'h6
`define ASI_OE_SLAVE     4'ha

`endif

// ===== core/asi_pkg.sv
// types shared by the serial interface modules
package asi_pkg;

    typedef enum logic [1:0] {
        ASI_MASTER = 2'b00,
        ASI_SLAVE  = 2'b01,
        ASI_ASYNC7 = 2'b10,
        ASI_ASYNC8 = 2'b11
    } asi_mode_t;

    typedef enum logic [1:0] {
        ASI_DIV16 = 2'b00,
        ASI_DIV8  = 2'b01,
        ASI_DIV4  = 2'b10,
        ASI_TIMER = 2'b11
    } asi_clk_t;

    typedef struct packed {
        logic [3:0] cnt;
        logic       tick;
    } asi_baud_t;

    typedef struct packed {
        logic [6:0]  setup;
        logic        rxen;
        logic        txen;
        logic        framing_error_flag;
        logic        parity_error_flag;
        logic        overrun_error_flag;
        logic [1:0]  pri;
        logic [2:0]  ien;
        logic [2:0]  ifac;
        logic        tx_busy;
        logic [10:0] tx_sh;
        logic [3:0]  tx_left;
        logic [3:0]  tx_sub;
        logic        rx_busy;
        logic        rx_frm;
        logic [8:0]  rx_sh;
        logic [3:0]  rx_left;
        logic [3:0]  rx_sub;
        logic [7:0]  tx_data;
        logic [7:0]  rdata;
        logic        mclk;
        logic        sclk_prev;
        logic [3:0]  pin_out;
        logic [3:0]  pin_oe;
        logic [3:0]  gpio_din;
        logic [1:0]  irq;
    } asi_core_t;

endpackage : asi_pkg

// ===== core/asi_ifs.sv
// bit clock and byte stream interfaces between the serial interface modules
`timescale 1ns/10ps
`default_nettype none

interface asi_clk_if;
    logic [1:0] sel;
    logic       fosc_tick;
    logic       timer_tick;
    logic       tick;
    modport gen  (input sel, input fosc_tick, input timer_tick, output tick);
    modport core (output sel, output fosc_tick, output timer_tick, input tick);
endinterface : asi_clk_if

interface asi_stream_if #(parameter int W = 8);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : asi_stream_if

`default_nettype wire

// ===== core/asi_baud.sv
// bit clock: fast oscillator ticks divided by 4, 8 or 16, or the timer tick
`timescale 1ns/10ps
`default_nettype none
`include "asi_defs.svh"

module asi_baud (
    // clock and reset
    input  wire logic sys_clk_in,
    input  wire logic reset_in,
    // select in, tick out
    asi_clk_if.gen    clk_if
);
    import asi_pkg::*;

    asi_baud_t  q;
    asi_baud_t  d;
    logic [3:0] last;

    always_comb begin
        d = q;
        d.tick = 1'b0;
        last = `ASI_LAST_DIV16;
        unique case (asi_clk_t'(clk_if.sel))
            ASI_DIV4:  last = `ASI_LAST_DIV4;
            ASI_DIV8:  last = `ASI_LAST_DIV8;
            ASI_DIV16: last = `ASI_LAST_DIV16;
            ASI_TIMER: last = `ASI_LAST_DIV16;
        endcase
        if (asi_clk_t'(clk_if.sel) == ASI_TIMER) begin
            d.tick = clk_if.timer_tick;
        end else if (clk_if.fosc_tick) begin
            d.cnt = q.cnt + 4'h1;
            // >= so a narrower divider picked mid-count restarts cleanly
            if (q.cnt >= last) begin
                d.cnt = 4'h0;
                d.tick = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign clk_if.tick = q.tick;

endmodule : asi_baud

`default_nettype wire

// ===== core/asi_fifo.sv
// receive byte buffer in flip-flops, valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none

module asi_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 32
) (
    // clock and reset
    input  wire logic sys_clk_in,
    input  wire logic reset_in,
    // fill and drain sides
    asi_stream_if.snk in_if,
    asi_stream_if.src out_if
);
    // depth must be a power of two: pointers wrap by overflow
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wp;
        logic [AW-1:0]           rp;
        logic [AW:0]             cnt;
    } asi_fifo_t;

    asi_fifo_t q;
    asi_fifo_t d;
    logic      push;
    logic      pop;

    assign in_if.ready  = (q.cnt != (AW+1)'(DEPTH));
    assign out_if.valid = (q.cnt != '0);
    assign out_if.data  = q.mem[q.rp];
    assign push = in_if.valid & in_if.ready;
    assign pop  = out_if.valid & out_if.ready;

    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wp] = in_if.data;
            d.wp = q.wp + 1'b1;
        end
        if (pop) begin
            d.rp = q.rp + 1'b1;
        end
        d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

endmodule : asi_fifo

`default_nettype wire

// ===== core/asi_top.sv
// serial interface: async 7/8-bit with parity, clock synchronous master/slave
// Notes on behaviour
// - mode field: 11 async 8-bit, 10 async 7-bit, 01 sync slave, 00 master
// - clock field: 11 timer tick, 10 fast clock/4, 01 /8, 00 /16
// - sync slave shifts on the external clock, clock field ignored
// - async only: parity enable adds parity bit, odd select picks odd
// - enable bit gives pins to serial function, else general port
// - pin directions follow the selected mode automatically when enabled
// - async uses data in, data out and handshake out
// - framing, parity, overrun flags read 1; write 1 clears, 0 ignored
// - writing 1 to a trigger starts it; the bit reads 1 while running
// - triggers share an address with status; software writes 1 only where meant
// - data register: written byte is sent, read returns received byte
// - error, receive, transmit interrupt enables at D2, D1, D0, reset off
// - factor flags set on each event whatever the enables hold
// - writing 1 clears a factor flag, writing 0 leaves it
// - two-bit priority gives level 0..3, 0 meaning disabled
// - clearing receive or transmit enable resets that section
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "asi_defs.svh"

module asi_top (
    // clock and reset
    input  wire logic        sys_clk_in,
    input  wire logic        reset_in,
    // register port
    input  wire logic [15:0] reg_addr_in,
    input  wire logic [7:0]  reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [7:0]  reg_rdata_out,
    // clock sources
    input  wire logic        fosc_tick_in,
    input  wire logic        timer_tick_in,
    // port pins 0..3
    input  wire logic [3:0]  port_pin_in,
    output logic      [3:0]  port_pin_out,
    output logic      [3:0]  port_pin_oe_out,
    // general port side
    input  wire logic [3:0]  gpio_dout_in,
    input  wire logic [3:0]  gpio_dir_in,
    output logic      [3:0]  gpio_din_out,
    // interrupt request level
    output logic      [1:0]  irq_level_out
);
    import asi_pkg::*;

    localparam asi_core_t CORE_RST = '{
        setup: `ASI_RST_SETUP,
        pri:   `ASI_RST_PRI,
        ien:   `ASI_RST_IEN,
        tx_sh: '1,
        mclk:  1'b1,
        default: '0
    };

    asi_core_t q;
    asi_core_t d;
    asi_mode_t mode;
    logic      serial_function_enable;
    logic      async;
    logic      slave;
    logic      par_en;
    logic      odd;
    logic      serial_input_pin;
    logic      stick;
    logic      srise;
    logic      wr_ctl;
    logic      tx_go;
    logic      rx_go;
    logic      tx_bit;
    logic      rx_bit;
    logic      tx_done;
    logic      rx_done;
    logic      fer_set;
    logic      per_set;
    logic      oer_set;
    logic      tpar;
    logic [3:0]  nbits;
    logic [3:0]  dlen;
    logic [7:0]  txd;
    logic [8:0]  rx_src;
    logic [8:0]  rx_al;
    logic [7:0]  rx_byte;
    logic        rx_pbit;
    logic [3:0]  oe;
    logic [3:0]  pv;

    asi_clk_if             bclk ();
    asi_stream_if #(.W(8)) rx_in ();
    asi_stream_if #(.W(8)) rx_out ();

    function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
        return a == ofs;
    endfunction : hit

    asi_baud u_baud (
        .sys_clk_in (sys_clk_in),
        .reset_in   (reset_in),
        .clk_if     (bclk)
    );

    asi_fifo #(.W(8), .DEPTH(32)) u_fifo (
        .sys_clk_in (sys_clk_in),
        .reset_in   (reset_in),
        .in_if      (rx_in),
        .out_if     (rx_out)
    );

    assign mode   = asi_mode_t'(q.setup[`ASI_SET_MD_LSB +: 2]);
    assign serial_function_enable   = q.setup[`ASI_SET_EN];
    assign async  = mode[1];
    assign slave  = (mode == ASI_SLAVE);
    assign par_en = async & q.setup[`ASI_SET_PAR_EN];
    assign odd    = q.setup[`ASI_SET_PAR_ODD];
    assign serial_input_pin    = port_pin_in[0];

    assign bclk.sel        = q.setup[`ASI_SET_CS_LSB +: 2];
    assign bclk.fosc_tick  = fosc_tick_in;
    assign bclk.timer_tick = timer_tick_in;
    assign stick           = bclk.tick;

    // master edges come from its own clock, slave edges from the pin
    assign srise = (mode == ASI_MASTER) ? (stick & ~q.mclk & (q.tx_busy | q.rx_busy))
                                        : (slave & port_pin_in[2] & ~q.sclk_prev);

    assign dlen  = async ? ((mode == ASI_ASYNC8) ? 4'h8 : 4'h7) + 4'(par_en) : `ASI_SYNC_BITS;
    assign nbits = async ? dlen + 4'h2 : dlen;

    // transmit frame, LSB first; unused upper bits are idle ones
    assign txd  = (mode == ASI_ASYNC7) ? {1'b0, q.tx_data[6:0]} : q.tx_data;
    assign tpar = par_en ? (^txd ^ odd) : 1'b1;

    // received bits enter at the top; align them down to bit 0
    assign rx_src  = async ? q.rx_sh : {serial_input_pin, q.rx_sh[8:1]};
    assign rx_al   = rx_src >> (4'h9 - dlen);
    assign rx_byte = (mode == ASI_ASYNC7) ? {1'b0, rx_al[6:0]} : rx_al[7:0];
    assign rx_pbit = (mode == ASI_ASYNC7) ? rx_al[7] : rx_al[8];

    assign wr_ctl = reg_wr_in & hit(reg_addr_in, `ASI_OFS_CTRL);
    // a trigger acts only when written 1 with its enable bit; a 0 in an enable bit resets that section
    assign tx_go  = wr_ctl & reg_wdata_in[`ASI_CTL_TXTRG] & reg_wdata_in[`ASI_CTL_TXEN]
                  & serial_function_enable & ~q.tx_busy;
    assign rx_go  = wr_ctl & reg_wdata_in[`ASI_CTL_RXTRG] & reg_wdata_in[`ASI_CTL_RXEN]
                  & serial_function_enable & ~q.rx_busy;

    assign rx_in.valid  = rx_done;
    assign rx_in.data   = rx_byte;
    assign rx_out.ready = reg_rd_in & hit(reg_addr_in, `ASI_OFS_DATA);

    always_comb begin
        d = q;
        tx_bit = 1'b0;
        rx_bit = 1'b0;
        tx_done = 1'b0;
        rx_done = 1'b0;
        fer_set = 1'b0;
        per_set = 1'b0;
        oe = `ASI_OE_ASYNC;
        pv = 4'h0;

        if (reg_wr_in) begin
            if (hit(reg_addr_in, `ASI_OFS_PRI)) begin
                d.pri = reg_wdata_in[`ASI_PRI_LSB +: 2];
            end
            if (hit(reg_addr_in, `ASI_OFS_IEN)) begin
                d.ien = reg_wdata_in[2:0];
            end
            if (hit(reg_addr_in, `ASI_OFS_IFAC)) begin
                d.ifac = q.ifac & ~reg_wdata_in[2:0];
            end
            if (hit(reg_addr_in, `ASI_OFS_SETUP)) begin
                d.setup = reg_wdata_in[6:0];
            end
            if (hit(reg_addr_in, `ASI_OFS_DATA)) begin
                d.tx_data = reg_wdata_in;
            end
            if (wr_ctl) begin
                d.rxen = reg_wdata_in[`ASI_CTL_RXEN];
                d.txen = reg_wdata_in[`ASI_CTL_TXEN];
                if (reg_wdata_in[`ASI_CTL_FER]) begin
                    d.framing_error_flag = 1'b0;
                end
                if (reg_wdata_in[`ASI_CTL_PER]) begin
                    d.parity_error_flag = 1'b0;
                end
                if (reg_wdata_in[`ASI_CTL_OER]) begin
                    d.overrun_error_flag = 1'b0;
                end
            end
        end

        // transmit section
        if (!d.txen) begin
            d.tx_busy = 1'b0;
            d.tx_sh = '1;
        end else if (tx_go) begin
            d.tx_busy = 1'b1;
            d.tx_left = nbits;
            d.tx_sub = 4'h0;
            d.tx_sh = async ? {1'b1, tpar, txd, 1'b0} : {3'b111, q.tx_data};
            if (async && mode == ASI_ASYNC7) begin
                d.tx_sh = {2'b11, tpar, txd[6:0], 1'b0};
            end
        end else if (q.tx_busy) begin
            if (async && stick) begin
                d.tx_sub = q.tx_sub + 4'h1;
                tx_bit = (q.tx_sub == `ASI_OVS_LAST);
            end else if (!async) begin
                tx_bit = srise;
            end
        end
        if (tx_bit) begin
            d.tx_sh = {1'b1, q.tx_sh[10:1]};
            d.tx_left = q.tx_left - 4'h1;
            if (q.tx_left == 4'h1) begin
                d.tx_busy = 1'b0;
                tx_done = 1'b1;
            end
        end

        // receive section: one byte per trigger
        if (!d.rxen) begin
            d.rx_busy = 1'b0;
            d.rx_frm = 1'b0;
        end else if (rx_go) begin
            d.rx_busy = 1'b1;
            d.rx_frm = ~async;
            d.rx_left = nbits;
            d.rx_sub = 4'h0;
        end else if (q.rx_busy) begin
            if (!async) begin
                rx_bit = srise;
            end else if (stick) begin
                d.rx_sub = q.rx_sub + 4'h1;
                if (!q.rx_frm) begin
                    if (!serial_input_pin) begin
                        d.rx_frm = 1'b1;
                        d.rx_sub = 4'h0;
                    end
                end else begin
                    rx_bit = (q.rx_sub == `ASI_OVS_MID);
                end
            end
        end
        if (rx_bit) begin
            d.rx_left = q.rx_left - 4'h1;
            if (async && q.rx_left == nbits) begin
                // a start bit gone high by mid-bit was noise: rearm
                if (serial_input_pin) begin
                    d.rx_frm = 1'b0;
                    d.rx_left = q.rx_left;
                end
            end else if (async && q.rx_left == 4'h1) begin
                rx_done = 1'b1;
                fer_set = ~serial_input_pin;
                per_set = par_en & ((^rx_byte ^ rx_pbit) != odd);
            end else begin
                d.rx_sh = {serial_input_pin, q.rx_sh[8:1]};
                rx_done = ~async & (q.rx_left == 4'h1);
            end
        end
        if (rx_done) begin
            d.rx_busy = 1'b0;
            d.rx_frm = 1'b0;
        end
        // the buffer refuses a byte only when all 32 slots are unread
        oer_set = rx_done & ~rx_in.ready;

        // event flags last, so a set beats a clear in the same cycle
        if (fer_set) begin
            d.framing_error_flag = 1'b1;
        end
        if (per_set) begin
            d.parity_error_flag = 1'b1;
        end
        if (oer_set) begin
            d.overrun_error_flag = 1'b1;
        end
        if (fer_set || per_set || oer_set) begin
            d.ifac[`ASI_IRQ_ERR] = 1'b1;
        end
        if (rx_done) begin
            d.ifac[`ASI_IRQ_RX] = 1'b1;
        end
        if (tx_done) begin
            d.ifac[`ASI_IRQ_TX] = 1'b1;
        end

        // master clock idles high and toggles only while shifting
        if (mode == ASI_MASTER && (q.tx_busy || q.rx_busy)) begin
            if (stick) begin
                d.mclk = ~q.mclk;
            end
        end else begin
            d.mclk = 1'b1;
        end
        d.sclk_prev = port_pin_in[2];

        // pin roles per mode; pin 0 is always serial input
        unique case (mode)
            ASI_ASYNC8, ASI_ASYNC7: begin
                oe = `ASI_OE_ASYNC;
                pv[2] = ~q.rx_busy;
            end
            ASI_MASTER: begin
                oe = `ASI_OE_MASTER;
                pv[2] = q.mclk;
            end
            ASI_SLAVE: begin
                oe = `ASI_OE_SLAVE;
                pv[3] = ~(q.rx_busy | q.tx_busy);
            end
        endcase
        pv[1] = q.tx_sh[0];
        d.pin_oe  = serial_function_enable ? oe : gpio_dir_in;
        d.pin_out = serial_function_enable ? pv : gpio_dout_in;
        d.gpio_din = port_pin_in;

        d.irq = (|(q.ifac & q.ien)) ? q.pri : 2'h0;

        d.rdata = 8'h00;
        if (reg_rd_in) begin
            if (hit(reg_addr_in, `ASI_OFS_PRI)) begin
                d.rdata[`ASI_PRI_LSB +: 2] = q.pri;
            end
            if (hit(reg_addr_in, `ASI_OFS_IEN)) begin
                d.rdata[2:0] = q.ien;
            end
            if (hit(reg_addr_in, `ASI_OFS_IFAC)) begin
                d.rdata[2:0] = q.ifac;
            end
            if (hit(reg_addr_in, `ASI_OFS_SETUP)) begin
                d.rdata[6:0] = q.setup;
            end
            if (wr_ctl | (reg_rd_in & hit(reg_addr_in, `ASI_OFS_CTRL))) begin
                d.rdata[6:0] = {q.framing_error_flag, q.parity_error_flag, q.overrun_error_flag, q.rx_busy, q.rxen, q.tx_busy, q.txen};
            end
            if (hit(reg_addr_in, `ASI_OFS_DATA)) begin
                d.rdata = rx_out.data;
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            q <= CORE_RST;
        end else begin
            q <= d;
        end
    end

    assign reg_rdata_out   = q.rdata;
    assign port_pin_out    = q.pin_out;
    assign port_pin_oe_out = q.pin_oe;
    assign gpio_din_out    = q.gpio_din;
    assign irq_level_out   = q.irq;

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (reset_in);

    pin_dir_a: assert property (serial_function_enable && async |=> port_pin_oe_out == `ASI_OE_ASYNC)
        else $error("pin directions wrong in async mode");
    gpio_pass_a: assert property (!serial_function_enable |=> port_pin_oe_out == $past(gpio_dir_in))
        else $error("port pins not left to general port");
    tx_idle_a: assert property (serial_function_enable && async && !q.tx_busy |=> port_pin_out[1])
        else $error("idle serial output not high");
    start_bit_a: assert property (tx_go && async |=> ##1 !port_pin_out[1])
        else $error("no low start bit after trigger");
    tx_run_a: assert property (tx_go && async |=> q.tx_busy [*8])
        else $error("transmit status dropped too early");
    rx_reset_a: assert property (wr_ctl && !reg_wdata_in[`ASI_CTL_RXEN] |=> !q.rx_busy)
        else $error("receive section not reset");
    fer_clr_a: assert property (wr_ctl && reg_wdata_in[`ASI_CTL_FER] && !fer_set |=> !q.framing_error_flag)
        else $error("framing flag not cleared by write of 1");
    fer_irq_a: assert property (fer_set |=> q.framing_error_flag && q.ifac[`ASI_IRQ_ERR])
        else $error("framing error not flagged");
    fac_clr_a: assert property (reg_wr_in && hit(reg_addr_in, `ASI_OFS_IFAC)
        && reg_wdata_in[`ASI_IRQ_RX] && !rx_done |=> !q.ifac[`ASI_IRQ_RX])
        else $error("receive factor not cleared");
    irq_lvl_a: assert property (|(q.ifac & q.ien) |=> irq_level_out == $past(q.pri))
        else $error("interrupt level differs from priority");
    overrun_a: assert property (rx_done && !rx_in.ready |=> q.overrun_error_flag)
        else $error("overrun not flagged");
    rd_data_a: assert property (rx_out.ready |=> reg_rdata_out == $past(rx_out.data))
        else $error("data read does not return buffered byte");

    tx_frame_c: cover property (tx_done && async);
    rx_frame_c: cover property (rx_done && !slave);
    overrun_c: cover property (oer_set);

endmodule : asi_top

`default_nettype wire

// ===== tb/asi_remote.sv
// remote async terminal: sends frames on serial in, captures frames on serial out
`timescale 1ns/10ps
`default_nettype none

module asi_remote #(
    parameter int BIT_CYC = 16
) (
    input  wire logic       clk_in,
    input  wire logic [3:0] pin_out_in,
    input  wire logic [3:0] pin_oe_in,
    output logic      [3:0] pin_in_out
);
    logic       sdrv = 1'b1;
    logic       line;
    logic [9:0] frame_q = 10'h000;
    logic [7:0] sync_q  = 8'h00;

    // undriven line reads as idle high
    assign line = pin_oe_in[1] ? pin_out_in[1] : 1'b1;
    assign pin_in_out = {1'b0, pin_oe_in[2] ? pin_out_in[2] : 1'b1, line, sdrv};

    // sample mid-bit: data, parity, stop
    always begin
        @(negedge line);
        repeat (BIT_CYC / 2) @(posedge clk_in);
        for (int i = 0; i < 10; i++) begin
            repeat (BIT_CYC) @(posedge clk_in);
            frame_q[i] = line;
        end
    end

    // sync master partner: data stands still while the shift clock falls
    always @(negedge pin_out_in[2]) sync_q <= {pin_out_in[1], sync_q[7:1]};

    // spoil[0] breaks even parity, spoil[1] pulls the stop bit low
    task automatic send(input logic [7:0] b, input logic [1:0] spoil);
        logic [10:0] f;
        f = {~spoil[1], ^b ^ spoil[0], b, 1'b0};
        for (int i = 0; i < 11; i++) begin
            sdrv <= f[i];
            repeat (BIT_CYC) @(posedge clk_in);
        end
        sdrv <= 1'b1;
    endtask : send
endmodule : asi_remote

`default_nettype wire

// ===== tb/asi_top_tb_top.sv
// bench for the serial interface: register tasks and frame exchange
`timescale 1ns/10ps
`default_nettype none
`include "asi_defs.svh"

module asi_top_tb_top;
    logic        sys_clk = 1'b0;
    logic        rst     = 1'b1;
    logic [15:0] addr    = 16'h0000;
    logic [7:0]  wdata   = 8'h00;
    logic        wr      = 1'b0;
    logic        rd      = 1'b0;
    logic        tmr     = 1'b0;
    logic        fosc    = 1'b0;
    logic [3:0]  gpin;
    logic [7:0]  rdata;
    logic [3:0]  pin_in;
    logic [3:0]  pin_out;
    logic [3:0]  pin_oe;
    logic [1:0]  irq;
    logic [7:0]  d;
    logic [15:0] regs [6] = '{16'hff20, 16'hff23, 16'hff25, 16'hff48, 16'hff49, 16'hff00};
    int          error_cnt = 0;
    int          n_checks  = 0;
    int          cyc       = 0;

    always #4 sys_clk = ~sys_clk;

    // fast oscillator pulse every other cycle
    always @(posedge sys_clk) fosc <= ~fosc;

    asi_top u_dut (
        .sys_clk_in(sys_clk), .reset_in(rst), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .fosc_tick_in(fosc),
        .timer_tick_in(tmr), .port_pin_in(pin_in), .port_pin_out(pin_out),
        .port_pin_oe_out(pin_oe), .gpio_dout_in(4'ha), .gpio_dir_in(4'hf),
        .gpio_din_out(gpin), .irq_level_out(irq)
    );

    asi_remote u_rem (.clk_in(sys_clk), .pin_out_in(pin_out), .pin_oe_in(pin_oe),
        .pin_in_out(pin_in));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr_reg(input logic [15:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [15:0] a);
        @(posedge sys_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg

    // bounded poll of the factor flags
    task automatic wait_fac(input int b);
        for (int i = 0; i < 300; i++) begin
            rd_reg(`ASI_OFS_IFAC);
            if (d[b] === 1'b1) break;
        end
    endtask : wait_fac

    task automatic give_verdict;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : give_verdict

    // three async frames and one sync byte need about 800 cycles
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            give_verdict();
        end
    end

    initial begin
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        tmr <= 1'b1;
        foreach (regs[i]) begin
            rd_reg(regs[i]);
            chk(d, 8'h00);
        end
        chk({pin_oe, pin_out}, 8'hfa);
        chk({4'h0, gpin}, 8'h03);
        wr_reg(`ASI_OFS_SETUP, 8'h5f);
        wr_reg(`ASI_OFS_PRI, 8'h20);
        wr_reg(`ASI_OFS_IEN, 8'h07);
        wr_reg(`ASI_OFS_CTRL, 8'h05);
        rd_reg(`ASI_OFS_SETUP);
        chk(d, 8'h5f);
        chk({4'h0, pin_oe}, {4'h0, `ASI_OE_ASYNC});
        wr_reg(`ASI_OFS_DATA, 8'ha5);
        wr_reg(`ASI_OFS_CTRL, 8'h07);
        rd_reg(`ASI_OFS_CTRL);
        chk(d, 8'h07);
        wait_fac(0);
        chk(d, 8'h01);
        chk({6'h0, irq}, 8'h02);
        repeat (20) @(posedge sys_clk);
        chk(u_rem.frame_q[7:0], 8'ha5);
        chk({6'h0, u_rem.frame_q[9:8]}, 8'h02);
        rd_reg(`ASI_OFS_CTRL);
        chk(d, 8'h05);
        wr_reg(`ASI_OFS_IFAC, 8'h01);
        rd_reg(`ASI_OFS_IFAC);
        chk(d, 8'h00);
        chk({6'h0, irq}, 8'h00);
        wr_reg(`ASI_OFS_CTRL, 8'h0d);
        u_rem.send(8'h3c, 2'b00);
        wait_fac(1);
        chk(d, 8'h02);
        rd_reg(`ASI_OFS_DATA);
        chk(d, 8'h3c);
        wr_reg(`ASI_OFS_IFAC, 8'h02);
        wr_reg(`ASI_OFS_CTRL, 8'h0d);
        // bad parity and a low stop bit in one frame
        u_rem.send(8'h3c, 2'b11);
        wait_fac(2);
        chk(d & 8'h04, 8'h04);
        wr_reg(`ASI_OFS_CTRL, 8'h05);
        rd_reg(`ASI_OFS_CTRL);
        chk(d & 8'h70, 8'h60);
        wr_reg(`ASI_OFS_CTRL, 8'h25);
        rd_reg(`ASI_OFS_CTRL);
        chk(d & 8'h70, 8'h40);
        wr_reg(`ASI_OFS_CTRL, 8'h45);
        rd_reg(`ASI_OFS_CTRL);
        chk(d & 8'h70, 8'h00);
        wr_reg(`ASI_OFS_IFAC, 8'h07);
        rd_reg(`ASI_OFS_IFAC);
        chk(d, 8'h00);
        // sync master at fast clock / 4: 16 ticks of 8 cycles per byte
        wr_reg(`ASI_OFS_SETUP, 8'h11);
        wr_reg(`ASI_OFS_DATA, 8'h5a);
        wr_reg(`ASI_OFS_CTRL, 8'h03);
        chk({4'h0, pin_oe}, {4'h0, `ASI_OE_MASTER});
        repeat (100) @(posedge sys_clk);
        rd_reg(`ASI_OFS_CTRL);
        chk(d, 8'h03);
        repeat (60) @(posedge sys_clk);
        rd_reg(`ASI_OFS_IFAC);
        chk(d, 8'h01);
        chk(u_rem.sync_q, 8'h5a);
        give_verdict();
    end
endmodule : asi_top_tb_top

`default_nettype wire
